// file: common/dscp_pkg.sv
// Purpose: Shared constants and types of the dual-slot card power serial control.
// Assumes: Nine-bit control word, shifted most significant bit first.
// Notes:   Rail states are codes; the analog switch matrix turns them into switch closures.
package dscp_pkg;

   // ==========================================================
   // Control word layout
   localparam int WORD_W        = 9;   // D0 through D8
   localparam int BIT_PROG_A_HI = 0;   // Slot A prog pair, first bit
   localparam int BIT_PROG_A_LO = 1;   // Slot A prog pair, second bit
   localparam int BIT_SUP_A_LO  = 2;   // Slot A supply pair, second bit
   localparam int BIT_SUP_A_HI  = 3;   // Slot A supply pair, first bit
   localparam int BIT_PROG_B_HI = 4;   // Slot B prog pair, first bit
   localparam int BIT_PROG_B_LO = 5;   // Slot B prog pair, second bit
   localparam int BIT_SUP_B_HI  = 6;   // Slot B supply pair, first bit
   localparam int BIT_SUP_B_LO  = 7;   // Slot B supply pair, second bit
   localparam int BIT_PWR_DOWN  = 8;   // Power-down bit, 0 means shut down
   localparam logic [8:0] WORD_RST = 9'h000;  // Word after reset
   localparam int SYNC_W        = 2;   // Flops in each pin synchroniser
   localparam int NUM_OUT       = 4;   // Supply A, prog A, supply B, prog B

   // ==========================================================
   // Supply rail states
   typedef enum logic [1:0] {
      DSCP_SUP_HIZ = 2'b00,   // All switches open
      DSCP_SUP_GND = 2'b01,   // Ground switch closed
      DSCP_SUP_LOW = 2'b10,   // 3.3 V rail selected
      DSCP_SUP_HIGH = 2'b11   // 5 V rail selected
   } dscp_sup_type;

   // Programming rail states
   typedef enum logic [1:0] {
      DSCP_PRG_HIZ = 2'b00,   // All switches open
      DSCP_PRG_GND = 2'b01,   // Ground switch closed
      DSCP_PRG_VCC = 2'b10,   // Follows the slot supply
      DSCP_PRG_12V = 2'b11    // 12 V input selected
   } dscp_prg_type;

   // Every output of both slots
   typedef struct packed {
      dscp_sup_type supply_a;
      dscp_prg_type prog_a;
      dscp_sup_type supply_b;
      dscp_prg_type prog_b;
   } dscp_rails_type;

   localparam dscp_rails_type RAILS_GND = '{DSCP_SUP_GND, DSCP_PRG_GND,
                                            DSCP_SUP_GND, DSCP_PRG_GND};
   localparam dscp_rails_type RAILS_HIZ = '{DSCP_SUP_HIZ, DSCP_PRG_HIZ,
                                            DSCP_SUP_HIZ, DSCP_PRG_HIZ};

endpackage

// file: verification/dscp_host_model.sv
// Purpose: Host controller model that drives the three-wire serial link.
// Assumes: Link clock of 15 ns period that runs only within a frame.
// Notes:   The data line shows the inverse of its last bit between frames.
`timescale 1ns/1ps

module dscp_host_model (
   // Serial link towards the switch
   output logic link_clk_out,
   output logic serial_data_out,
   output logic serial_latch_out
);

   // ==========================================================
   // Idle state of the link
   initial begin
      link_clk_out     = 1'b0;
      serial_data_out  = 1'b0;
      serial_latch_out = 1'b0;
   end

   // ==========================================================
   // One frame: nine bits, then a latch pulse
   task automatic send_word(input logic [8:0] word);
      for (int i = 8; i >= 0; i--) begin
         serial_data_out = word[i];        // Bit settles before the rising edge
         #7.5;
         link_clk_out = 1'b1;
         #7.5;
         link_clk_out = 1'b0;
      end
      serial_data_out = ~word[0];          // Released line does not keep its value
      #20;
      serial_latch_out = 1'b1;             // Latch before any further clock edge
      #200;
      serial_latch_out = 1'b0;             // Clock stays still while the word loads
      #200;
   endtask

endmodule

// file: verification/tb.sv
// Purpose: Self-checking bench of the dual-slot power serial control.
// Assumes: Core clock 40 ns; fault and reset pins driven 1 ns after a rising edge.
// Notes:   Expected rail states are decoded here from the control word.
`timescale 1ns/1ps

module tb;
   import dscp_pkg::*;

   // ==========================================================
   // Signals
   logic           core_clk_in, rst_b_in, card_reset_in, card_reset_b_in;
   logic           thermal_trip_in, below_ground_in;
   logic [3:0]     oc_sense_in, current_limit_out;
   logic           link_clk, serial_data, serial_latch;
   dscp_rails_type rails_out;
   logic           overcurrent_flag_n_out, quiescent_low_out, latched_off_out;
   int             bad_count = 0;
   int             checks = 0;

   // ==========================================================
   // Design and far-side host
   dscp_ctrl u_dscp_ctrl (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
      .link_clk_in(link_clk), .serial_data_in(serial_data), .serial_latch_in(serial_latch),
      .card_reset_in(card_reset_in), .card_reset_b_in(card_reset_b_in),
      .oc_sense_in(oc_sense_in), .thermal_trip_in(thermal_trip_in),
      .below_ground_in(below_ground_in), .rails_out(rails_out),
      .current_limit_out(current_limit_out), .overcurrent_flag_n_out(overcurrent_flag_n_out),
      .quiescent_low_out(quiescent_low_out), .latched_off_out(latched_off_out));
   dscp_host_model u_dscp_host_model (.link_clk_out(link_clk), .serial_data_out(serial_data),
      .serial_latch_out(serial_latch));

   // Core clock
   initial begin
      core_clk_in = 1'b0;
      forever #20 core_clk_in = ~core_clk_in;
   end

   // ==========================================================
   // Helpers
   function automatic dscp_sup_type sup(input logic [1:0] c);
      return (c == 2'b01) ? DSCP_SUP_LOW : (c == 2'b10) ? DSCP_SUP_HIGH : DSCP_SUP_GND;
   endfunction
   function automatic dscp_prg_type prg(input logic [1:0] c);
      return (c == 2'b00) ? DSCP_PRG_GND : (c == 2'b01) ? DSCP_PRG_VCC :
             (c == 2'b10) ? DSCP_PRG_12V : DSCP_PRG_HIZ;
   endfunction
   // Expected rails for a latched word
   function automatic dscp_rails_type exp_rails(input logic [8:0] w);
      if (!w[8]) begin
         return RAILS_HIZ;
      end
      return '{sup({w[3], w[2]}), prg({w[0], w[1]}), sup({w[6], w[7]}), prg({w[4], w[5]})};
   endfunction
   // Word with power on from the four pair codes
   function automatic logic [8:0] mk(input logic [1:0] pa, sa, pb, sb);
      return {1'b1, sb[0], sb[1], pb[0], pb[1], sa[1], sa[0], pa[0], pa[1]};
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_in);
      #1;
   endtask
   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic load(input logic [8:0] w);
      u_dscp_host_model.send_word(w);
      tick(1);
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset();
      check(rails_out, RAILS_GND);
      check({current_limit_out, overcurrent_flag_n_out, quiescent_low_out}, 8'h02);
   endtask
   task automatic t_decode();
      logic [8:0] w;
      for (int c = 0; c < 4; c++) begin
         w = mk(2'(c), 2'(c + 1), 2'(c + 2), 2'(c + 3));
         load(w);
         check(rails_out, exp_rails(w));
         check(quiescent_low_out, 1'b0);
      end
      load(w & 9'h0ff);
      check(rails_out, RAILS_HIZ);
      check(quiescent_low_out, 1'b1);
   endtask
   task automatic t_card_reset();
      for (int p = 0; p < 2; p++) begin
         load(mk(2'h2, 2'h2, 2'h2, 2'h2));
         if (p == 0) card_reset_in = 1'b1;
         else card_reset_b_in = 1'b0;
         tick(4);
         check(rails_out, RAILS_GND);
         load(mk(2'h1, 2'h1, 2'h1, 2'h1));
         check(rails_out, RAILS_GND);
         card_reset_in = 1'b0;
         card_reset_b_in = 1'b1;
         tick(10);
         check(rails_out, RAILS_GND);
         load(mk(2'h1, 2'h1, 2'h1, 2'h1));
         check(rails_out, exp_rails(mk(2'h1, 2'h1, 2'h1, 2'h1)));
      end
   endtask
   task automatic t_faults();
      load(mk(2'h2, 2'h1, 2'h2, 2'h2));
      for (int i = 0; i < 4; i++) begin
         oc_sense_in = 4'(1 << i);
         tick(4);
         check(current_limit_out, 8'(1 << i));
         check(overcurrent_flag_n_out, 1'b0);
         check(rails_out, exp_rails(mk(2'h2, 2'h1, 2'h2, 2'h2)));
         oc_sense_in = 4'h0;
         tick(4);
         check(overcurrent_flag_n_out, 1'b1);
      end
      thermal_trip_in = 1'b1;
      tick(4);
      check(rails_out, RAILS_HIZ);
      thermal_trip_in = 1'b0;
      tick(4);
      check(rails_out, exp_rails(mk(2'h2, 2'h1, 2'h2, 2'h2)));
   endtask
   task automatic t_migrate();
      load(mk(2'h0, 2'h2, 2'h0, 2'h2));
      check(rails_out, exp_rails(mk(2'h0, 2'h2, 2'h0, 2'h2)));
      load(mk(2'h0, 2'h0, 2'h0, 2'h0));
      check(rails_out, RAILS_GND);
      load(mk(2'h0, 2'h1, 2'h0, 2'h1));
      check(rails_out, exp_rails(mk(2'h0, 2'h1, 2'h0, 2'h1)));
   endtask
   task automatic t_lockout();
      below_ground_in = 1'b1;
      tick(5);
      check({latched_off_out, rails_out}, {1'b1, RAILS_HIZ});
      below_ground_in = 1'b0;
      load(mk(2'h0, 2'h1, 2'h0, 2'h1));
      check(rails_out, RAILS_HIZ);
      rst_b_in = 1'b0;
      tick(2);
      rst_b_in = 1'b1;
      tick(2);
      check({latched_off_out, rails_out}, {1'b0, RAILS_GND});
   endtask

   // ==========================================================
   // Verdict and end of run
   task automatic finish_test();
      if (bad_count == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // Watchdog against a hang
   initial begin
      #200000;
      bad_count++;
      finish_test();
   end

   // Main sequence
   initial begin
      {card_reset_in, thermal_trip_in, below_ground_in, oc_sense_in} = '0;
      card_reset_b_in = 1'b1;
      rst_b_in = 1'b0;
      repeat (12) @(posedge core_clk_in);
      #1;
      rst_b_in = 1'b1;
      tick(2);
      t_reset();
      t_decode();
      t_card_reset();
      t_faults();
      t_migrate();
      t_lockout();
      finish_test();
   end

endmodule

// file: verilog/dscp_ctrl.sv
// Purpose: Serial control logic of a dual-slot card power switch.
// Assumes: Serial clock is its own domain; other pins are asynchronous to core_clk_in.
// Notes:   Shift stage is quasi-static once the latch pin rises, so the core samples it.
`timescale 1ns/1ps

// Rules for this block and its host controller
// [R1] One data bit shifted per rising serial clock
// [R2] Latch rising edge loads D0..D8 into word
// [R3] Controller latches before next serial clock edge
// [R4] Power-down bit opens all outputs, quiescent mode
// [R5] Slot A prog pair D0,D1 decoded
// [R6] Reset closes only the four ground switches
// [R7] Stay grounded until fresh word after reset
// [R8] Reset accepted on active-high or active-low pin
// [R9] Overcurrent flag low when any output overcurrent
// [R10] Only the faulting output is current limited
// [R11] Thermal trip disables all outputs until cool
// [R12] Below-ground fault latches off until power cycle
// [R13] Ground state actively discharges supply outputs
// [R14] Controller grounds before moving 5 V to 3.3 V
// [R15] Controller powers new card at 5 V first
// [R16] Slot B prog pair D4,D5 decoded
// [R17] Slot A supply pair D3,D2 decoded
// [R18] Slot B supply pair D6,D7 decoded
// [R19] D8 shifted first, D0 last
// [R20] Word reads all-grounded until first latch
module dscp_ctrl (
   // Core clock and power-on reset
   input  wire logic                     core_clk_in,
   input  wire logic                     rst_b_in,
   // Serial link
   input  wire logic                     link_clk_in,
   input  wire logic                     serial_data_in,
   input  wire logic                     serial_latch_in,
   // Card reset pins
   input  wire logic                     card_reset_in,
   input  wire logic                     card_reset_b_in,
   // Fault sense from the analog section
   input  wire logic [3:0]               oc_sense_in,
   input  wire logic                     thermal_trip_in,
   input  wire logic                     below_ground_in,
   // Rail controls and status
   output dscp_pkg::dscp_rails_type      rails_out,
   output logic [3:0]                    current_limit_out,
   output logic                          overcurrent_flag_n_out,
   output logic                          quiescent_low_out,
   output logic                          latched_off_out
);
   import dscp_pkg::*;

   // ==========================================================
   // Declarations
   logic [WORD_W-1:0] shift_r;        // Serial shift stage, link domain
   logic [SYNC_W:0]   latch_sync_r;   // Latch synchroniser plus edge stage
   logic [SYNC_W-1:0] rst_hi_sync_r;  // Active-high reset synchroniser
   logic [SYNC_W-1:0] rst_lo_sync_r;  // Active-low reset synchroniser
   logic [3:0]        oc_sync1_r;     // Overcurrent first stage
   logic [3:0]        oc_sync2_r;     // Overcurrent second stage
   logic [1:0]        flt_sync1_r;    // Thermal and below-ground first stage
   logic [1:0]        flt_sync2_r;    // Thermal and below-ground second stage
   logic [WORD_W-1:0] word_r;         // Active switch-control word
   logic              word_valid_r;   // A fresh word has been latched
   logic              latched_off_r;  // Below-ground lockout
   logic              reset_act;      // Either reset pin asserted
   logic              latch_rise;     // Rising edge of the latch pin
   dscp_rails_type    rails_nxt;      // Next rail state

   // ==========================================================
   // Decode functions
   // Supply pair: 00 ground, 01 low rail, 10 high rail, 11 ground
   function automatic dscp_sup_type sup_dec(input logic first_b, input logic second_b);
      dscp_sup_type s;
      s = DSCP_SUP_GND;
      case ({first_b, second_b})
         2'b01:   s = DSCP_SUP_LOW;
         2'b10:   s = DSCP_SUP_HIGH;
         default: s = DSCP_SUP_GND;
      endcase
      return s;
   endfunction

   // Prog pair: 00 ground, 01 follow supply, 10 12 V, 11 open
   function automatic dscp_prg_type prg_dec(input logic first_b, input logic second_b);
      dscp_prg_type p;
      p = DSCP_PRG_HIZ;
      case ({first_b, second_b})
         2'b00:   p = DSCP_PRG_GND;
         2'b01:   p = DSCP_PRG_VCC;
         2'b10:   p = DSCP_PRG_12V;
         default: p = DSCP_PRG_HIZ;
      endcase
      return p;
   endfunction

   // ==========================================================
   // Link domain: serial shift stage
   // New bit enters at the bottom, so the first bit ends at D8
   always_ff @(posedge link_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         shift_r <= WORD_RST;
      end else begin
         shift_r <= {shift_r[WORD_W-2:0], serial_data_in};  // [R1] [R19]
      end
   end

   // ==========================================================
   // Pin synchronisers
   // Latch pin, two flops then an edge stage
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         latch_sync_r <= '0;
      end else begin
         latch_sync_r <= {latch_sync_r[SYNC_W-1:0], serial_latch_in};
      end
   end

   // Reset pins; unused pin idles inactive
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rst_hi_sync_r <= '0;
         rst_lo_sync_r <= '1;
      end else begin
         rst_hi_sync_r <= {rst_hi_sync_r[0], card_reset_in};
         rst_lo_sync_r <= {rst_lo_sync_r[0], card_reset_b_in};
      end
   end

   // Fault sense inputs
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         oc_sync1_r  <= '0;
         oc_sync2_r  <= '0;
         flt_sync1_r <= '0;
         flt_sync2_r <= '0;
      end else begin
         oc_sync1_r  <= oc_sense_in;
         oc_sync2_r  <= oc_sync1_r;
         flt_sync1_r <= {below_ground_in, thermal_trip_in};
         flt_sync2_r <= flt_sync1_r;
      end
   end

   // Edge decode from the second-stage and edge-stage flops; reset decode from second-stage flops only
   assign latch_rise = latch_sync_r[SYNC_W-1] & ~latch_sync_r[SYNC_W];  // [R2]
   assign reset_act  = rst_hi_sync_r[1] | ~rst_lo_sync_r[1];            // [R8]

   // ==========================================================
   // Active word
   // Reset clears the valid flag while word_r holds; only a latch after release restores it
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         word_r       <= WORD_RST;                 // [R20]
         word_valid_r <= 1'b0;                     // [R20]
      end else if (reset_act) begin
         word_valid_r <= 1'b0;                     // [R7]
      end else if (latch_rise) begin
         word_r       <= shift_r;                  // [R2]
         word_valid_r <= 1'b1;                     // [R7]
      end
   end

   // Below-ground lockout, cleared only by power-on reset
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         latched_off_r <= 1'b0;
      end else if (flt_sync2_r[1]) begin
         latched_off_r <= 1'b1;                    // [R12]
      end
   end

   // ==========================================================
   // Rail state selection
   always_comb begin
      rails_nxt = RAILS_GND;
      if (reset_act || !word_valid_r) begin
         rails_nxt = RAILS_GND;                    // [R6] [R7] [R13]
      end else if (flt_sync2_r[0] || latched_off_r) begin
         rails_nxt = RAILS_HIZ;                    // [R11] [R12]
      end else if (!word_r[BIT_PWR_DOWN]) begin
         rails_nxt = RAILS_HIZ;                    // [R4]
      end else begin
         rails_nxt.prog_a   = prg_dec(word_r[BIT_PROG_A_HI], word_r[BIT_PROG_A_LO]); // [R5]
         rails_nxt.supply_a = sup_dec(word_r[BIT_SUP_A_HI], word_r[BIT_SUP_A_LO]);   // [R17]
         rails_nxt.prog_b   = prg_dec(word_r[BIT_PROG_B_HI], word_r[BIT_PROG_B_LO]); // [R16]
         rails_nxt.supply_b = sup_dec(word_r[BIT_SUP_B_HI], word_r[BIT_SUP_B_LO]);   // [R18]
      end
   end

   // Registered outputs
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rails_out              <= RAILS_GND;
         current_limit_out      <= '0;
         overcurrent_flag_n_out <= 1'b1;
         quiescent_low_out      <= 1'b0;
         latched_off_out        <= 1'b0;
      end else begin
         rails_out              <= rails_nxt;
         current_limit_out      <= oc_sync2_r;     // [R10]
         overcurrent_flag_n_out <= ~|oc_sync2_r;   // [R9]
         quiescent_low_out      <= word_valid_r & ~reset_act
                                   & ~word_r[BIT_PWR_DOWN];  // [R4]
         latched_off_out        <= latched_off_r;
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_b_in);

   // Reset pin seen, then outputs grounded
   sequence s_reset_seen;
      reset_act;
   endsequence
   sequence s_grounded;
      rails_out == RAILS_GND;
   endsequence

   property p_reset_ground;
      s_reset_seen |=> s_grounded;
   endproperty
   a_reset_ground: assert property (p_reset_ground) else $error("reset not grounded"); // [R6]

   property p_stay_ground;
      (reset_act ##1 !reset_act && !latch_rise) |=> s_grounded;
   endproperty
   a_stay_ground: assert property (p_stay_ground) else $error("left ground early"); // [R7]

   property p_latch_load;
      (latch_rise && !reset_act) |=> (word_r == $past(shift_r) && word_valid_r);
   endproperty
   a_latch_load: assert property (p_latch_load) else $error("word not loaded"); // [R2]

   property p_power_down;
      (word_valid_r && !reset_act && !word_r[BIT_PWR_DOWN]) |=>
         (rails_out == RAILS_HIZ && quiescent_low_out);
   endproperty
   a_power_down: assert property (p_power_down) else $error("power down ignored"); // [R4]

   property p_oc_flag;
      (|oc_sync2_r) |=> !overcurrent_flag_n_out;
   endproperty
   a_oc_flag: assert property (p_oc_flag) else $error("overcurrent flag high"); // [R9]

   property p_oc_local;
      1'b1 |=> current_limit_out == $past(oc_sync2_r);
   endproperty
   a_oc_local: assert property (p_oc_local) else $error("wrong output limited"); // [R10]

   property p_thermal;
      (flt_sync2_r[0] && word_valid_r && !reset_act) |=> rails_out == RAILS_HIZ;
   endproperty
   a_thermal: assert property (p_thermal) else $error("thermal not off"); // [R11]

   property p_lockout;
      latched_off_r |=> latched_off_r;
   endproperty
   a_lockout: assert property (p_lockout) else $error("lockout cleared"); // [R12]

   property p_slot_a_prog;
      (word_valid_r && !reset_act && !flt_sync2_r[0] && !latched_off_r &&
       word_r[BIT_PWR_DOWN] && word_r[BIT_PROG_A_HI] && !word_r[BIT_PROG_A_LO])
         |=> rails_out.prog_a == DSCP_PRG_12V;
   endproperty
   a_slot_a_prog: assert property (p_slot_a_prog) else $error("slot a prog decode"); // [R5]

   property p_slot_b_sup;
      (word_valid_r && !reset_act && !flt_sync2_r[0] && !latched_off_r &&
       word_r[BIT_PWR_DOWN] && !word_r[BIT_SUP_B_HI] && word_r[BIT_SUP_B_LO])
         |=> rails_out.supply_b == DSCP_SUP_LOW;
   endproperty
   a_slot_b_sup: assert property (p_slot_b_sup) else $error("slot b supply decode"); // [R18]

endmodule
